// ---- src/qld_defs.svh ----
// constants for the quick link drop and line test register bank
// assumes a 25 MHz core clock and a 32-bit classic wishbone register port
`ifndef QLD_DEFS_SVH
`define QLD_DEFS_SVH

// register indexes, byte address is four times the index
`define QLD_IDX_LTC 6'h25
`define QLD_IDX_AMIX 6'h2c
`define QLD_IDX_FLD 6'h2d

// reset values
`define QLD_RST_LTC 16'h0080
`define QLD_RST_AMIX 16'h141f
`define QLD_RST_FLD 16'h0000

// writable bit masks, everything else reads zero or is status
`define QLD_WMASK_LTC 16'h03ff
`define QLD_WMASK_AMIX 16'h3fff
`define QLD_WMASK_FLD 16'hc01f

// line_test_control fields
`define QLD_LTC_EXT_MSB 9
`define QLD_LTC_EXT_EN 8
`define QLD_LTC_CHAN_ALL 7
`define QLD_LTC_CHAN_HI 6
`define QLD_LTC_CHAN_LO 5
`define QLD_LTC_T10_EN 4
`define QLD_LTC_PAT_HI 3
`define QLD_LTC_PAT_LO 0

// crossover_and_drop_window_timers fields
`define QLD_AMIX_WIN_HI 13
`define QLD_AMIX_WIN_LO 9
`define QLD_AMIX_FAST_HI 8
`define QLD_AMIX_FAST_LO 4
`define QLD_AMIX_ROB_HI 3
`define QLD_AMIX_ROB_LO 0

// link_drop_control_status fields
`define QLD_FLD_SILENT_DROP 15
`define QLD_FLD_SKIP_HOLD 14
`define QLD_FLD_STUCK 13
`define QLD_FLD_CAUSE_HI 12
`define QLD_FLD_CAUSE_LO 8
`define QLD_FLD_EN_HI 4
`define QLD_FLD_EN_LO 0

// timing
`define QLD_CLK_PERIOD_NS 40
`define QLD_WIN_UNIT_NS 1000
`define QLD_WIN_UNIT_CYC (`QLD_WIN_UNIT_NS / `QLD_CLK_PERIOD_NS)
`define QLD_FAST_UNIT_US 4000
`define QLD_FAST_UNIT_CYC (`QLD_FAST_UNIT_US * 1000 / `QLD_CLK_PERIOD_NS)
`define QLD_ROBUST_SPAN_US 500000
`define QLD_ROBUST_STEPS 15
`define QLD_ROBUST_UNIT_CYC (`QLD_ROBUST_SPAN_US * 1000 / `QLD_CLK_PERIOD_NS / `QLD_ROBUST_STEPS)
`define QLD_PRE_W 20

`endif

// ---- src/qld_pkg.sv ----
// types and shared decoders for the quick link drop register bank
// assumes qld_defs.svh is on the include path
package qld_pkg;

  // 10 Mb/s line test patterns
  typedef enum logic [3:0] {
    PAT_LINK_PULSE_SINGLE = 4'h0, PAT_PULSE_ONE = 4'h1, PAT_PULSE_ZERO = 4'h2,
    PAT_REP_ONE = 4'h3, PAT_REP_ZERO = 4'h4, PAT_PREAMBLE = 4'h5,
    PAT_ONE_THEN_IDLE = 4'h6, PAT_ZERO_THEN_IDLE = 4'h7, PAT_REP_1001 = 4'h8,
    PAT_RANDOM = 4'h9, PAT_IDLE_00 = 4'ha, PAT_IDLE_01 = 4'hb,
    PAT_IDLE_10 = 4'hc, PAT_IDLE_11 = 4'hd
  } qld_pat_t;

  // channel select field to per-channel drive enables
  function automatic logic [3:0] qld_chan_decode(input logic [2:0] sel);
    qld_chan_decode = sel[2] ? 4'hf : (4'h1 << sel[1:0]);
  endfunction : qld_chan_decode

  // byte-lane write merge limited to the writable bits
  function automatic logic [15:0] qld_merge(input logic [15:0] old, input logic [15:0] wdat,
                                            input logic [1:0] sel, input logic [15:0] mask);
    logic [15:0] lane;
    lane = {{8{sel[1]}}, {8{sel[0]}}} & mask;
    qld_merge = (old & ~lane) | (wdat & lane);
  endfunction : qld_merge

endpackage : qld_pkg

// ---- src/qld_unit_timer.sv ----
// interval timer: prescaler of UNIT_CYC clocks times a programmable unit count
// assumes run comes from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module qld_unit_timer #(
  parameter int unsigned UNIT_CYC = 25,
  parameter int unsigned PW = 20
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  input wire logic [4:0] units,
  output logic expire_q
);
  logic [PW-1:0] pre_q;
  logic [4:0] unit_q;
  wire unit_tick = (pre_q == PW'(UNIT_CYC - 1));
  // a unit count of zero behaves as one, so the timer never stalls
  wire [4:0] last_unit = (units == 5'h00) ? 5'h00 : units - 5'h01;
  wire wrap = unit_tick && (unit_q >= last_unit);

  // counters restart whenever the timer is idle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_q <= '0;
      unit_q <= 5'h00;
      expire_q <= 1'b0;
    end else if (ce) begin
      pre_q <= (!run || unit_tick) ? '0 : pre_q + PW'(1);
      unit_q <= (!run || wrap) ? 5'h00 : (unit_tick ? unit_q + 5'h01 : unit_q);
      expire_q <= run && wrap;
    end
  end
endmodule : qld_unit_timer
`default_nettype wire

// ---- src/qld_top.sv ----
// line test control, crossover timers and quick link drop register bank
// assumes a classic wishbone master on ref_clk and PHY indications on ref_clk
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "qld_defs.svh"
module qld_top
  import qld_pkg::*;
#(
  parameter int unsigned FAST_UNIT_CYC = `QLD_FAST_UNIT_CYC,
  parameter int unsigned ROBUST_UNIT_CYC = `QLD_ROBUST_UNIT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [4:0] crit_event,
  input wire logic no_signal,
  input wire logic slicer_stuck,
  input wire logic xover_fast_mode,
  input wire logic xover_robust_mode,
  input wire logic link_up,
  output logic [3:0] test_chan_en,
  output logic test10_en,
  output logic [3:0] test10_pattern,
  output logic ext100_en,
  output logic ext100_bit,
  output logic mdix_cross,
  output logic quick_link_drop,
  output logic silent_drop
);
  logic [15:0] ltc_q;
  logic [15:0] amix_q;
  logic [15:0] fld_q;
  logic [4:0] cause_q;
  logic [4:0] hit_q;
  logic stuck_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [3:0] chan_q;
  logic t10_q;
  logic [3:0] pat_q;
  logic ext_en_q;
  logic ext_bit_q;
  logic [4:0] ext_cnt_q;
  logic cross_q;
  logic drop_q;
  logic silent_q;
  logic win_exp;
  logic fast_exp;
  logic rob_exp;

  // bus request decode; the word index sits above the two byte bits
  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire [5:0] word = wb_adr_i[7:2];
  wire hit_ltc = (word == `QLD_IDX_LTC);
  wire hit_amix = (word == `QLD_IDX_AMIX);
  wire hit_fld = (word == `QLD_IDX_FLD);
  wire wr = req && wb_we_i;
  wire rd_fld = req && !wb_we_i && hit_fld;
  wire [15:0] wdat = wb_dat_i[15:0];
  wire [1:0] lanes = wb_sel_i[1:0];

  // status view of the drop register, reserved 7:5 read zero
  wire [15:0] fld_view = {fld_q[`QLD_FLD_SILENT_DROP], fld_q[`QLD_FLD_SKIP_HOLD], stuck_q,
                          cause_q, 3'h0, fld_q[`QLD_FLD_EN_HI:`QLD_FLD_EN_LO]};
  // unmapped addresses answer with zero
  wire [15:0] rd_val = hit_ltc ? ltc_q : (hit_amix ? amix_q : (hit_fld ? fld_view : 16'h0000));

  // register writes take effect with the edge that raises ack
  wire [15:0] ltc_d = (wr && hit_ltc) ? qld_merge(ltc_q, wdat, lanes, `QLD_WMASK_LTC) : ltc_q;
  wire [15:0] amix_d = (wr && hit_amix) ? qld_merge(amix_q, wdat, lanes, `QLD_WMASK_AMIX) : amix_q;
  wire [15:0] fld_d = (wr && hit_fld) ? qld_merge(fld_q, wdat, lanes, `QLD_WMASK_FLD) : fld_q;

  // bus slave: one wait state, ack for one cycle, then a gap
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      ltc_q <= `QLD_RST_LTC;
      amix_q <= `QLD_RST_AMIX;
      fld_q <= `QLD_RST_FLD;
    end else if (ce) begin
      ack_q <= req;
      dat_q <= req && !wb_we_i ? {16'h0000, rd_val} : 32'h0000_0000;
      ltc_q <= ltc_d;
      amix_q <= amix_d;
      fld_q <= fld_d;
    end
  end

  // line test decode
  wire ext_run = ltc_q[`QLD_LTC_EXT_EN] && !ltc_q[`QLD_LTC_T10_EN];
  wire [4:0] ext_n = {ltc_q[`QLD_LTC_EXT_MSB], ltc_q[`QLD_LTC_PAT_HI:`QLD_LTC_PAT_LO]};
  wire [3:0] pat = ltc_q[`QLD_LTC_PAT_HI:`QLD_LTC_PAT_LO];
  // codes above the idle variants have no pattern and start nothing
  wire pat_legal = (pat <= PAT_IDLE_11);
  wire [3:0] chan_d = qld_chan_decode(ltc_q[`QLD_LTC_CHAN_ALL:`QLD_LTC_CHAN_LO]);
  wire ext_clear = !ext_run || (ext_n == 5'h00);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chan_q <= 4'h0;
      t10_q <= 1'b0;
      pat_q <= 4'h0;
    end else if (ce) begin
      chan_q <= chan_d;
      t10_q <= ltc_q[`QLD_LTC_T10_EN] && pat_legal;
      pat_q <= pat;
    end
  end

  // one followed by N zeros; the count wraps at N
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_en_q <= 1'b0;
      ext_bit_q <= 1'b0;
      ext_cnt_q <= 5'h00;
    end else if (ce) begin
      ext_en_q <= ext_run;
      ext_bit_q <= !ext_clear && (ext_cnt_q == 5'h00);
      ext_cnt_q <= (ext_clear || ext_cnt_q >= ext_n) ? 5'h00 : ext_cnt_q + 5'h01;
    end
  end

  // window runs only while some criterion is enabled
  wire [4:0] crit_en = fld_q[`QLD_FLD_EN_HI:`QLD_FLD_EN_LO];
  qld_unit_timer #(
    .UNIT_CYC(`QLD_WIN_UNIT_CYC),
    .PW(`QLD_PRE_W)
  ) u_window (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .run(|crit_en),
    .units(amix_q[`QLD_AMIX_WIN_HI:`QLD_AMIX_WIN_LO]),
    .expire_q(win_exp)
  );

  // crossover timers are held cleared while link is up
  qld_unit_timer #(
    .UNIT_CYC(FAST_UNIT_CYC),
    .PW(`QLD_PRE_W)
  ) u_fast (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .run(xover_fast_mode && !link_up),
    .units(amix_q[`QLD_AMIX_FAST_HI:`QLD_AMIX_FAST_LO]),
    .expire_q(fast_exp)
  );

  qld_unit_timer #(
    .UNIT_CYC(ROBUST_UNIT_CYC),
    .PW(`QLD_PRE_W)
  ) u_robust (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .run(xover_robust_mode && !xover_fast_mode && !link_up),
    .units({1'b0, amix_q[`QLD_AMIX_ROB_HI:`QLD_AMIX_ROB_LO]}),
    .expire_q(rob_exp)
  );

  // criteria in the order energy, mse, mlt3, rx error, descrambler
  wire [4:0] live = crit_en & crit_event;
  wire [4:0] seen = hit_q | live;
  wire skip = fld_q[`QLD_FLD_SKIP_HOLD];
  wire [4:0] fire = skip ? live : (win_exp ? seen : 5'h00);
  wire rd_clr = rd_fld && lanes[1];

  // per-criterion latches; a set in the read cycle survives the clear
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_cause
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          cause_q[gi] <= 1'b0;
          hit_q[gi] <= 1'b0;
        end else if (ce) begin
          cause_q[gi] <= fire[gi] || (cause_q[gi] && !rd_clr);
          hit_q[gi] <= !win_exp && !skip && seen[gi];
        end
      end
    end
  endgenerate

  // drop and crossover outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drop_q <= 1'b0;
      silent_q <= 1'b0;
      stuck_q <= 1'b0;
      cross_q <= 1'b0;
    end else if (ce) begin
      drop_q <= |fire;
      silent_q <= fld_q[`QLD_FLD_SILENT_DROP] && no_signal;
      stuck_q <= slicer_stuck;
      cross_q <= cross_q ^ (fast_exp || rob_exp);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign test_chan_en = chan_q;
  assign test10_en = t10_q;
  assign test10_pattern = pat_q;
  assign ext100_en = ext_en_q;
  assign ext100_bit = ext_bit_q;
  assign mdix_cross = cross_q;
  assign quick_link_drop = drop_q;
  assign silent_drop = silent_q;

  // checks on the decoded outputs and the drop flags
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // the release edge still loads the cleared decode, so the attempt waits for reset to be gone
  property p_chan_all;
    ce && !rst && ltc_q[`QLD_LTC_CHAN_ALL] |=> test_chan_en == 4'hf;
  endproperty
  a_chan_all: assert property (p_chan_all) else $error("all-channel select ignored");

  property p_chan_one;
    ce && !ltc_q[`QLD_LTC_CHAN_ALL] |=> test_chan_en == (4'h1 << $past(ltc_q[6:5]));
  endproperty
  a_chan_one: assert property (p_chan_one) else $error("single channel wrong");

  property p_t10_gate;
    ce && !ltc_q[`QLD_LTC_T10_EN] |=> !test10_en;
  endproperty
  a_t10_gate: assert property (p_t10_gate) else $error("10M test without enable");

  property p_t10_random;
    ce && ltc_q[4:0] == 5'h19 |=> test10_en && test10_pattern == 4'h9;
  endproperty
  a_t10_random: assert property (p_t10_random) else $error("random pattern not selected");

  // a length of two held from a fresh count: one, zero, zero
  sequence s_ext_two;
    ce && ext_run && ext_n == 5'h02 && ext_cnt_q == 5'h00 ##1 (ce && ext_run && ext_n == 5'h02) [*2];
  endsequence
  property p_ext_gap;
    s_ext_two |-> !ext100_bit && $past(ext100_bit) ##1 !ext100_bit;
  endproperty
  a_ext_gap: assert property (p_ext_gap) else $error("extended test one-zero order wrong");

  property p_ext_clear;
    ce && ext_clear |=> !ext100_bit;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("cleared shift register still sends");

  property p_silent;
    ce && fld_q[15] && no_signal |=> silent_drop;
  endproperty
  a_silent: assert property (p_silent) else $error("silence did not drop link");

  property p_skip;
    ce && skip |=> (cause_q & $past(live)) == $past(live) && quick_link_drop == |$past(live);
  endproperty
  a_skip: assert property (p_skip) else $error("skip mode did not drop at once");

  property p_hold_window;
    ce && !skip && !win_exp |=> (cause_q & ~$past(cause_q)) == 5'h00 && !quick_link_drop;
  endproperty
  a_hold_window: assert property (p_hold_window) else $error("drop before window end");

  property p_latch;
    ce && !rd_clr |=> (cause_q & $past(cause_q)) == $past(cause_q);
  endproperty
  a_latch: assert property (p_latch) else $error("cause flag lost without read");

  property p_reserved;
    wb_ack_o && !wb_we_i && hit_amix |-> wb_dat_o[31:14] == 18'h00000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

  property p_cross;
    ce && !fast_exp && !rob_exp |=> mdix_cross == $past(mdix_cross);
  endproperty
  a_cross: assert property (p_cross) else $error("crossover toggled without timer");
endmodule : qld_top
`default_nettype wire

// ---- test/qld_link_partner.sv ----
// cable partner stand-in: line indications seen by the register bank
// assumes the bench sets the wanted line state; slow adds a cycle of lag
`timescale 1ns/10ps
`default_nettype none
module qld_link_partner (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [7:0] want,
  output logic [7:0] line_q
);
  logic [7:0] lag_q;
  // receiver decode lag; a slow partner shows its state one cycle later
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lag_q <= 8'h00;
      line_q <= 8'h00;
    end else begin
      lag_q <= want;
      line_q <= slow ? lag_q : want;
    end
  end
endmodule : qld_link_partner
`default_nettype wire

// ---- test/qld_top_tb.sv ----
// self-checking bench for the line test and quick link drop register bank
// assumes short crossover units and the behavioural cable partner
`timescale 1ns/10ps
`default_nettype none
module qld_top_tb;
  localparam int FU = 10; // short fast unit keeps the run brief
  localparam int RU = 20;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0, test_chan_en, test10_pattern;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, r;
  logic xover_fast_mode = 1'b0, xover_robust_mode = 1'b0, slow = 1'b0, p, m;
  logic want_quiet = 1'b0, want_stuck = 1'b0, want_up = 1'b0;
  logic [4:0] want_crit = 5'h00, en, ev;
  logic [9:0] v;
  logic test10_en, ext100_en, ext100_bit, mdix_cross, quick_link_drop, silent_drop;
  wire [4:0] crit_event;
  wire no_signal, slicer_stuck, link_up;
  logic [7:0] ad [4] = '{8'h94, 8'hb0, 8'hb4, 8'hfc};
  logic [15:0] rv [4] = '{16'h0080, 16'h141f, 16'h0000, 16'h0000};
  logic [15:0] mk [4] = '{16'h03ff, 16'h3fff, 16'hc01f, 16'h0000};
  logic [4:0] nl [5] = '{5'h01, 5'h1f, 5'h00, 5'h06, 5'h02};
  int miscompares = 0, num_checks = 0, n;

  // 25 MHz core clock
  always #20 ref_clk = ~ref_clk;

  qld_top #(.FAST_UNIT_CYC(FU), .ROBUST_UNIT_CYC(RU)) dut_u (.ref_clk, .rst, .ce, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .crit_event, .no_signal, .slicer_stuck,
    .xover_fast_mode, .xover_robust_mode, .link_up, .test_chan_en, .test10_en, .test10_pattern, .ext100_en,
    .ext100_bit, .mdix_cross, .quick_link_drop, .silent_drop);
  qld_link_partner lp_u (.ref_clk, .rst, .slow, .want({want_up, want_stuck, want_quiet, want_crit}),
    .line_q({link_up, slicer_stuck, no_signal, crit_event}));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // one classic cycle; request held until ack is sampled, data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int i;
    i = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge ref_clk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 40);
    check("ack", wb_ack_o, 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  // first event only syncs, the second gives the interval
  task automatic gap(input logic pulse, input int exp);
    int i;
    logic t;
    repeat (2) begin
      i = 0;
      t = mdix_cross;
      do begin
        @(negedge ref_clk);
        i++;
      end while ((pulse ? quick_link_drop !== 1'b1 : mdix_cross === t) && i < 2000);
    end
    check("interval", i, exp);
  endtask : gap

  // {channels, 10M enable, pattern, extended 100M enable}; codes e and f start no test
  function automatic logic [9:0] ltc_out(input logic [9:0] c);
    logic [3:0] ch;
    ch = c[7] ? 4'hf : 4'h1 << c[6:5];
    return {ch, c[4] && c[3:0] < 4'he, c[3:0], c[8] && !c[4]};
  endfunction : ltc_out

  // main sequence
  initial begin
    void'($urandom(32'h02e4825c));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(negedge ref_clk);
    check("chan at reset", test_chan_en, 4'hf);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      bus(0, ad[i], 16'h0000);
      check("reset value", q, rv[i]);
      bus(1, ad[i], 16'hffff);
      bus(0, ad[i], 16'h0000);
      check("ones", q, mk[i]);
      bus(1, ad[i], r[15:0]);
      bus(0, ad[i], 16'h0000);
      check("random", q, r[15:0] & mk[i]);
      bus(1, ad[i], rv[i]);
    end
    // every channel code and pattern code, then free random values
    for (int i = 0; i < 48; i++) begin
      r = $urandom;
      v = (i < 32) ? {r[9:8], i[2:0], i[4:0]} : r[9:0];
      bus(1, 8'h94, {6'h00, v});
      @(negedge ref_clk);
      check("test outs", {test_chan_en, test10_en, test10_pattern, ext100_en}, ltc_out(v));
    end
    // extended 100M stream: cleared before each new length
    foreach (nl[j]) begin
      bus(1, 8'h94, 16'h0000);
      bus(1, 8'h94, {6'h00, nl[j][4], 5'b11000, nl[j][3:0]});
      n = 0;
      while (ext100_bit !== 1'b1 && n < 80) begin
        @(negedge ref_clk);
        n++;
      end
      for (int k = 0; k < nl[j]; k++) begin
        @(negedge ref_clk);
        check("zero", ext100_bit, 1'b0);
      end
      @(negedge ref_clk);
      check("one", ext100_bit, nl[j] != 5'h00);
    end
    // crossover timers, fast then robust, frozen once linked
    bus(1, 8'hb0, 16'h1421);
    xover_fast_mode <= 1'b1;
    gap(1'b0, 2 * FU);
    @(posedge ref_clk);
    xover_fast_mode <= 1'b0;
    xover_robust_mode <= 1'b1;
    gap(1'b0, RU);
    bus(1, 8'hb0, 16'h1413);
    gap(1'b0, 3 * RU);
    want_up <= 1'b1;
    repeat (4) @(negedge ref_clk);
    m = mdix_cross;
    repeat (100) @(negedge ref_clk);
    check("linked", mdix_cross, m);
    // observation window length follows the count field
    bus(1, 8'hb4, 16'h0001);
    want_crit <= 5'h01;
    for (int w = 1; w < 4; w += 2) begin
      bus(1, 8'hb0, {2'b00, w[4:0], 9'h01f});
      gap(1'b1, w * 25);
    end
    bus(1, 8'hb0, 16'h041f);
    // single enables against all criteria, then random mixes
    for (int k = 0; k < 10; k++) begin
      r = $urandom;
      en = (k < 5) ? 5'h01 << k : r[4:0];
      ev = (k < 5) ? 5'h1f : r[9:5];
      bus(1, 8'hb4, {11'h000, en});
      want_crit <= ev;
      want_stuck <= r[10];
      slow <= r[11];
      p = 1'b0;
      repeat (160) begin
        @(negedge ref_clk);
        p |= quick_link_drop;
      end
      @(posedge ref_clk);
      want_crit <= 5'h00;
      repeat (70) @(posedge ref_clk);
      bus(0, 8'hb4, 16'h0000);
      check("status", q, {r[10], en & ev, 3'b000, en});
      check("drop seen", p, |(en & ev));
      bus(0, 8'hb4, 16'h0000);
      check("cleared", q, {r[10], 8'h00, en});
    end
    // skipping the hold drops well before a 31 us window
    bus(1, 8'hb0, 16'h3e1f);
    bus(1, 8'hb4, 16'h4001);
    want_crit <= 5'h01;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (quick_link_drop !== 1'b1 && n < 900);
    check("quick drop", n < 5, 1'b1);
    bus(1, 8'hb4, 16'h8000);
    want_crit <= 5'h00;
    want_quiet <= 1'b1;
    repeat (4) @(negedge ref_clk);
    check("silent", silent_drop, 1'b1);
    // clock enable low must freeze the drop output even when the line comes back
    @(posedge ref_clk);
    ce <= 1'b0;
    want_quiet <= 1'b0;
    repeat (6) @(negedge ref_clk);
    check("frozen", silent_drop, 1'b1);
    @(posedge ref_clk);
    ce <= 1'b1;
    want_quiet <= 1'b1;
    bus(1, 8'hb4, 16'h0000);
    @(negedge ref_clk);
    check("silent off", silent_drop, 1'b0);
    conclude();
  end

  // watchdog, well beyond the expected run
  initial begin
    #(40 * 30000);
    miscompares++;
    conclude();
  end
endmodule : qld_top_tb
`default_nettype wire
